// ===== pof_formatter.sv
// pixel output formatter: capture, mirror, crop, convert, format
`timescale 1ns/1ps
module pof_formatter #(
	parameter int MAX_W = 64,
	parameter int MAX_H = 48
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic in_valid,
	output logic in_ready,
	input wire pof_pkg::pof_pix_in_t in_pix,
	output logic out_valid,
	input wire logic out_ready,
	output pof_pkg::pof_pix_out_t out_pix
);
	localparam int XW = $clog2(MAX_W);
	localparam int YW = $clog2(MAX_H);
	localparam int AW = $clog2(MAX_W * MAX_H);

	typedef struct packed {
		pof_pkg::pof_phase_t phase;
		logic [3:0] fmt;
		logic rev_x;
		logic rev_y;
		logic [1:0] adc;
		logic acq_en;
		logic [1:0] mosaic;
		logic pat_src;
		logic sen_on;
		logic [1:0] pipe_mode;
		logic [15:0] off_x;
		logic [15:0] off_y;
		logic [15:0] roi_w;
		logic [15:0] roi_h;
		logic [XW:0] cx;
		logic [YW:0] cy;
		logic [XW:0] fw;
		logic [YW:0] fh;
		logic [XW:0] ox;
		logic [XW:0] ex;
		logic [YW:0] oy;
		logic [YW:0] ey;
		logic [7:0] ramp;
		logic [7:0] fseq;
		logic [15:0] frames;
		logic acq_prev;
		logic [15:0] chroma;
		logic ack;
		logic [31:0] rdat;
		logic in_rdy;
		logic out_vld;
		pof_pkg::pof_pix_out_t out;
	} pof_state_t;

	pof_state_t st_q;
	pof_state_t st_d;
	pof_pkg::pof_cell_t mem [MAX_W * MAX_H];
	pof_pkg::pof_cell_t cap;
	pof_pkg::pof_cell_t rd;
	logic acc;
	logic cap_we;
	logic adv;
	logic [AW-1:0] cap_idx;
	logic [AW-1:0] rd_idx;
	logic [23:0] ycc;
	logic [7:0] v_ramp;
	logic [1:0] colph;

	function automatic logic [AW-1:0] cell_idx(input int x, input int y);
		cell_idx = AW'(y * MAX_W + x);
	endfunction : cell_idx

	function automatic logic [7:0] sat8(input logic signed [19:0] acc_in);
		logic signed [19:0] t;
		t = (acc_in + pof_pkg::CONV_ROUND) >>> pof_pkg::CONV_SHIFT;
		if (t < 0) begin
			sat8 = 8'h00;
		end else if (t > 20'sd255) begin
			sat8 = 8'hFF;
		end else begin
			sat8 = t[7:0];
		end
	endfunction : sat8

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	assign wb_dat_o = st_q.rdat;
	assign wb_ack_o = st_q.ack;
	assign in_ready = st_q.in_rdy;
	assign out_valid = st_q.out_vld;
	assign out_pix = st_q.out;

	////////////////////////////////////////////////////////////////////////
	// capture side: pattern injection and sample alignment

	assign acc = in_valid & st_q.in_rdy;
	always_comb begin
		logic [XW:0] px;
		logic [YW:0] py;
		logic [7:0] v;
		px = in_pix.sof ? '0 : st_q.cx;
		py = in_pix.sof ? '0 : st_q.cy;
		v_ramp = in_pix.sof ? 8'h00 : st_q.ramp;
		cap.r = in_pix.r;
		cap.g = in_pix.g;
		cap.b = in_pix.b;
		unique case (st_q.adc)
			pof_pkg::ADC_8: cap.raw16 = {in_pix.raw[7:0], 8'h00};
			pof_pkg::ADC_10: cap.raw16 = {in_pix.raw[9:0], 6'h00};
			pof_pkg::ADC_12: cap.raw16 = {in_pix.raw[11:0], 4'h0};
			pof_pkg::ADC_14: cap.raw16 = {in_pix.raw, 2'h0};
		endcase
		// patterns are built after the sensor path, so gain never reaches them
		v = {8{px[3] ^ py[3]}};
		if (st_q.pipe_mode == pof_pkg::PAT_INCR) begin
			v = v_ramp;
		end else if (st_q.pipe_mode == pof_pkg::PAT_VARSEQ) begin
			v = 8'(px) + 8'(py) + st_q.fseq;
		end
		if (st_q.pipe_mode != pof_pkg::PAT_OFF || st_q.sen_on) begin
			cap = '{r: v, g: v, b: v, raw16: {v, 8'h00}};
		end
		cap_we = acc && (32'(px) < MAX_W) && (32'(py) < MAX_H);
		cap_idx = cell_idx(int'(px), int'(py));
	end

	always_ff @(posedge clk) begin
		if (cap_we) begin
			mem[cap_idx] <= cap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// drain side: mirrored read, crop, colour conversion

	always_comb begin
		logic [XW:0] sx;
		logic [YW:0] sy;
		sx = st_q.rev_x ? st_q.fw - st_q.ox - 1'b1 : st_q.ox;
		sy = st_q.rev_y ? st_q.fh - st_q.oy - 1'b1 : st_q.oy;
		rd_idx = cell_idx(int'(sx), int'(sy));
		rd = mem[rd_idx];
		ycc[7:0] = sat8(pof_pkg::Y_R * $signed({12'h0, rd.r})
			+ pof_pkg::Y_G * $signed({12'h0, rd.g})
			+ pof_pkg::Y_B * $signed({12'h0, rd.b}));
		ycc[15:8] = sat8(pof_pkg::CB_R * $signed({12'h0, rd.r})
			+ pof_pkg::CB_G * $signed({12'h0, rd.g})
			+ pof_pkg::CB_B * $signed({12'h0, rd.b})
			+ pof_pkg::CHROMA_OFS);
		ycc[23:16] = sat8(pof_pkg::CR_R * $signed({12'h0, rd.r})
			+ pof_pkg::CR_G * $signed({12'h0, rd.g})
			+ pof_pkg::CR_B * $signed({12'h0, rd.b})
			+ pof_pkg::CHROMA_OFS);
		colph = 2'(st_q.ox - st_q.off_x[XW:0]);
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [31:0] w;
		logic [XW:0] fw_n;
		logic [YW:0] fh_n;
		logic [16:0] ext;
		logic [7:0] cb;
		logic [7:0] cr;
		logic req;
		st_d = st_q;
		w = '0;
		fw_n = st_q.fw;
		fh_n = st_q.fh;
		ext = '0;
		cb = ycc[15:8];
		cr = ycc[23:16];
		adv = 1'b0;

		// register bus, one wait state per access
		req = wb_cyc_i & wb_stb_i & ~st_q.ack;
		st_d.ack = req;
		if (req) begin
			unique case (wb_adr_i)
				pof_pkg::REG_CTRL: w = {21'h0, st_q.mosaic, st_q.acq_en,
					st_q.adc, st_q.rev_y, st_q.rev_x, st_q.fmt};
				pof_pkg::REG_PATTERN: w = {28'h0, st_q.pipe_mode,
					st_q.sen_on, st_q.pat_src};
				pof_pkg::REG_ROI_OFFSET: w = {st_q.off_y, st_q.off_x};
				pof_pkg::REG_ROI_SIZE: w = {st_q.roi_h, st_q.roi_w};
				pof_pkg::REG_STATUS: w = {st_q.frames, 13'h0,
					st_q.phase == pof_pkg::POF_DRAIN,
					st_q.mosaic ^ {st_q.rev_y, st_q.rev_x}};
				default: w = '0;
			endcase
			st_d.rdat = w;
			w = merge(w, wb_dat_i, wb_sel_i);
			if (wb_we_i) begin
				unique case (wb_adr_i)
					pof_pkg::REG_CTRL: begin
						st_d.fmt = w[pof_pkg::CTRL_FMT_LSB +: 4];
						st_d.rev_x = w[pof_pkg::CTRL_REV_X];
						st_d.rev_y = w[pof_pkg::CTRL_REV_Y];
						st_d.adc = w[pof_pkg::CTRL_ADC_LSB +: 2];
						st_d.acq_en = w[pof_pkg::CTRL_ACQ];
						st_d.mosaic = w[pof_pkg::CTRL_MOSAIC_LSB +: 2];
					end
					pof_pkg::REG_PATTERN: begin
						st_d.pat_src = w[0];
						if (w[0] == pof_pkg::PAT_SRC_SENSOR) begin
							st_d.sen_on = w[2:1] == pof_pkg::PAT_SENSOR;
						end else if (w[2:1] == pof_pkg::PAT_SENSOR) begin
							st_d.pipe_mode = pof_pkg::PAT_OFF;
						end else begin
							st_d.pipe_mode = w[2:1];
						end
					end
					pof_pkg::REG_ROI_OFFSET: begin
						st_d.off_x = w[15:0];
						st_d.off_y = w[31:16];
					end
					pof_pkg::REG_ROI_SIZE: begin
						st_d.roi_w = w[15:0];
						st_d.roi_h = w[31:16];
					end
					default: begin
					end
				endcase
			end
		end

		// sequence restarts on every acquisition start
		st_d.acq_prev = st_q.acq_en;

		if (st_q.out_vld && out_ready) begin
			st_d.out_vld = 1'b0;
		end

		unique case (st_q.phase)
			pof_pkg::POF_FILL: begin
				if (acc) begin
					st_d.ramp = v_ramp + 8'h01;
					st_d.cx = in_pix.eol ? '0 : st_q.cx + 1'b1;
					if (in_pix.sof) begin
						st_d.cy = '0;
						st_d.cx = in_pix.eol ? '0 : (XW+1)'(1);
					end
					if (in_pix.eol) begin
						fw_n = (in_pix.sof ? '0 : st_q.cx) + 1'b1;
						st_d.fw = fw_n;
						st_d.cy = (in_pix.sof ? '0 : st_q.cy) + 1'b1;
					end
					if (in_pix.eof) begin
						fh_n = (in_pix.sof ? '0 : st_q.cy) + 1'b1;
						st_d.fh = fh_n;
						st_d.fseq = st_q.fseq + 8'h01;
						// crop window, taken in mirrored coordinates
						ext = {1'b0, st_q.off_x} + {1'b0, st_q.roi_w};
						st_d.ex = (ext > 17'(fw_n)) ? fw_n : ext[XW:0];
						ext = {1'b0, st_q.off_y} + {1'b0, st_q.roi_h};
						st_d.ey = (ext > 17'(fh_n)) ? fh_n : ext[YW:0];
						st_d.ox = st_q.off_x[XW:0];
						st_d.oy = st_q.off_y[YW:0];
						if (17'(st_q.off_x) < 17'(fw_n) && st_q.roi_w != '0
							&& 17'(st_q.off_y) < 17'(fh_n)
							&& st_q.roi_h != '0) begin
							st_d.phase = pof_pkg::POF_DRAIN;
						end
					end
				end
			end
			pof_pkg::POF_DRAIN: begin
				adv = !st_q.out_vld || out_ready;
				if (adv) begin
					st_d.out_vld = 1'b1;
					st_d.out.sof = st_q.ox == st_q.off_x[XW:0]
						&& st_q.oy == st_q.off_y[YW:0];
					st_d.out.eol = st_q.ox + 1'b1 == st_q.ex;
					st_d.out.eof = st_d.out.eol && st_q.oy + 1'b1 == st_q.ey;
					if (colph == 2'h0) begin
						st_d.chroma = {cr, cb};
					end else begin
						cb = st_q.chroma[7:0];
						cr = st_q.chroma[15:8];
					end
					st_d.out.nbytes = 3'h3;
					st_d.out.data = '0;
					unique case (st_q.fmt)
						pof_pkg::FMT_RGB: st_d.out.data = {8'h00, rd.b, rd.g,
							rd.r};
						pof_pkg::FMT_BGR: st_d.out.data = {8'h00, rd.r, rd.g,
							rd.b};
						pof_pkg::FMT_BGRA: begin
							st_d.out.data = {pof_pkg::ALPHA_OPAQUE, rd.r, rd.g,
								rd.b};
							st_d.out.nbytes = 3'h4;
						end
						pof_pkg::FMT_Y444: st_d.out.data = {8'h00, ycc};
						pof_pkg::FMT_Y444_ALT: st_d.out.data = {8'h00, ycc[23:16],
							ycc[7:0], ycc[15:8]};
						pof_pkg::FMT_Y422, pof_pkg::FMT_Y422_ALT: begin
							st_d.out.nbytes = 3'h2;
							st_d.out.data[15:0] = {colph[0] ? cr : cb, ycc[7:0]};
							if (st_q.fmt == pof_pkg::FMT_Y422_ALT) begin
								st_d.out.data[15:0] = {ycc[7:0], colph[0] ? cr : cb};
							end
						end
						pof_pkg::FMT_Y411, pof_pkg::FMT_Y411_ALT: begin
							st_d.out.nbytes = colph[0] ? 3'h1 : 3'h2;
							st_d.out.data[15:0] = colph[0] ? {8'h00, ycc[7:0]}
								: {colph[1] ? cr : cb, ycc[7:0]};
							if (st_q.fmt == pof_pkg::FMT_Y411_ALT && !colph[0]) begin
								st_d.out.data[15:0] = {ycc[7:0], colph[1] ? cr : cb};
							end
						end
						pof_pkg::FMT_MOSAIC_8: begin
							st_d.out.nbytes = 3'h1;
							st_d.out.data = {24'h0, rd.raw16[15:8]};
						end
						pof_pkg::FMT_MOSAIC_16: begin
							st_d.out.nbytes = 3'h2;
							st_d.out.data = {16'h0, rd.raw16};
						end
						default: st_d.out.data = '0;
					endcase
					st_d.ox = st_q.ox + 1'b1;
					if (st_d.out.eol) begin
						st_d.ox = st_q.off_x[XW:0];
						st_d.oy = st_q.oy + 1'b1;
					end
					if (st_d.out.eof) begin
						st_d.phase = pof_pkg::POF_FILL;
						st_d.frames = st_q.frames + 16'h0001;
					end
				end
			end
		endcase
		if (st_q.acq_en && !st_q.acq_prev) begin
			st_d.fseq = 8'h00;
		end
		// host must idle acquisition before a depth change
		st_d.in_rdy = st_d.phase == pof_pkg::POF_FILL && st_d.acq_en;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.phase <= pof_pkg::POF_FILL;
			st_q.fmt <= pof_pkg::CTRL_RESET[pof_pkg::CTRL_FMT_LSB +: 4];
			st_q.roi_w <= pof_pkg::ROI_SIZE_RESET;
			st_q.roi_h <= pof_pkg::ROI_SIZE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb_chk @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_wb_ack_timing: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
		|=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing wrong");
	a_out_hold_stall: assert property ((out_valid && !out_ready)
		|=> out_valid && $stable(out_pix)) else $error("output dropped");
	a_in_block_drain: assert property ((st_q.phase == pof_pkg::POF_DRAIN)
		|-> !in_ready) else $error("input open while draining");
	a_rgb_order: assert property ((adv && st_q.fmt == pof_pkg::FMT_BGR)
		|=> out_pix.data[23:0] == {$past(rd.r), $past(rd.g), $past(rd.b)})
		else $error("channel order wrong");
	a_luma_red: assert property ((adv && st_q.fmt == pof_pkg::FMT_Y444
		&& rd.r == 8'hFF && rd.g == 8'h00 && rd.b == 8'h00)
		|=> out_pix.data[7:0] == 8'h4C) else $error("luma wrong");
	a_cb_red: assert property ((adv && st_q.fmt == pof_pkg::FMT_Y444
		&& rd.r == 8'hFF && rd.g == 8'h00 && rd.b == 8'h00)
		|=> out_pix.data[15:8] == 8'h55) else $error("cb wrong");
	a_cr_saturate: assert property ((adv && st_q.fmt == pof_pkg::FMT_Y444
		&& rd.r == 8'hFF && rd.g == 8'h00 && rd.b == 8'h00)
		|=> out_pix.data[23:16] == 8'hFF) else $error("cr wrong");
	a_sample_align: assert property ((acc && st_q.adc == pof_pkg::ADC_12
		&& in_pix.raw[11:0] == 12'hFFF && !st_q.sen_on
		&& st_q.pipe_mode == pof_pkg::PAT_OFF) |-> cap.raw16 == 16'hFFF0)
		else $error("alignment wrong");
	a_ramp_wrap: assert property ((acc && !in_pix.sof && st_q.ramp == 8'hFF)
		|=> st_q.ramp == 8'h00) else $error("ramp no wrap");
	a_ramp_restart: assert property ((acc && in_pix.sof)
		|=> st_q.ramp == 8'h01) else $error("ramp no restart");
	a_seq_restart: assert property ($rose(st_q.acq_en)
		|=> st_q.fseq == 8'h00) else $error("sequence no restart");
	a_422_chroma: assert property ((adv && st_q.fmt == pof_pkg::FMT_Y422
		&& colph == 2'h1) |=> out_pix.nbytes == 3'h2
		&& out_pix.data[15:8] == $past(st_q.chroma[15:8]))
		else $error("422 chroma wrong");
	a_411_luma_only: assert property ((adv && st_q.fmt == pof_pkg::FMT_Y411
		&& colph[0]) |=> out_pix.nbytes == 3'h1)
		else $error("411 count wrong");
	a_pipe_overrides: assert property ((acc && st_q.sen_on
		&& st_q.pipe_mode == pof_pkg::PAT_INCR) |-> cap.r == v_ramp)
		else $error("pattern priority wrong");

	c_frame_out: cover property (out_valid && out_ready && out_pix.eof);
	c_mirror_both: cover property (adv && st_q.rev_x && st_q.rev_y);
	c_ycc_422: cover property (adv && st_q.fmt == pof_pkg::FMT_Y422);
	c_stall: cover property (out_valid && !out_ready ##1 out_ready);
endmodule : pof_formatter

// ===== pof_pkg.sv
// pixel output formatter: shared constants, codes and carrier types
// Notes on behaviour
// - interleaved colour: R,G,B / B,G,R / B,G,R,A bytes
// - luma from fixed weights 0.299, 0.587, 0.114
// - blue chroma from fixed weights plus 128
// - red chroma from fixed weights plus 128
// - 4:4:4 gives luma and both chromas each pixel
// - 4:2:2 alternates chroma per pixel, sampled every fourth pixel, luma every pixel
// - 4:1:1 quarters chroma horizontally, luma every pixel
// - narrow format drops surplus low sample bits
// - wide format left-aligns sample in 16 bits
// - full scale 65472, 65520, 65532 by depth
// - two generators, source select picks target
// - off disables selected generator, each keeps state
// - ramp adds one per pixel, wraps 255
// - frame sequence varies, restarts at acquisition start
// - pipeline-head pattern overrides sensor pattern
// - patterns unaffected by exposure, gain, black level
// - real sensor data only with both off
// - reverse x flips columns before crop, phase
// - reverse y flips rows before crop, phase
package pof_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PATTERN = 8'h04;
	localparam logic [7:0] REG_ROI_OFFSET = 8'h08;
	localparam logic [7:0] REG_ROI_SIZE = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	// control fields
	localparam int CTRL_FMT_LSB = 0;
	localparam int CTRL_REV_X = 4;
	localparam int CTRL_REV_Y = 5;
	localparam int CTRL_ADC_LSB = 6;
	localparam int CTRL_ACQ = 8;
	localparam int CTRL_MOSAIC_LSB = 9;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] ROI_SIZE_RESET = 16'hFFFF;
	// pixel formats
	localparam logic [3:0] FMT_RGB = 4'h0;
	localparam logic [3:0] FMT_BGR = 4'h1;
	localparam logic [3:0] FMT_BGRA = 4'h2;
	localparam logic [3:0] FMT_Y444 = 4'h3;
	localparam logic [3:0] FMT_Y444_ALT = 4'h4;
	localparam logic [3:0] FMT_Y422 = 4'h5;
	localparam logic [3:0] FMT_Y422_ALT = 4'h6;
	localparam logic [3:0] FMT_Y411 = 4'h7;
	localparam logic [3:0] FMT_Y411_ALT = 4'h8;
	localparam logic [3:0] FMT_MOSAIC_8 = 4'h9;
	localparam logic [3:0] FMT_MOSAIC_16 = 4'hA;
	localparam logic [7:0] ALPHA_OPAQUE = 8'hFF;
	// converter depth codes
	localparam logic [1:0] ADC_8 = 2'h0;
	localparam logic [1:0] ADC_10 = 2'h1;
	localparam logic [1:0] ADC_12 = 2'h2;
	localparam logic [1:0] ADC_14 = 2'h3;
	// pattern source and choice codes
	localparam logic PAT_SRC_SENSOR = 1'b0;
	localparam logic PAT_SRC_PIPE = 1'b1;
	localparam logic [1:0] PAT_OFF = 2'h0;
	localparam logic [1:0] PAT_SENSOR = 2'h1;
	localparam logic [1:0] PAT_INCR = 2'h2;
	localparam logic [1:0] PAT_VARSEQ = 2'h3;
	// colour conversion, weights scaled by 1024
	localparam int CONV_SHIFT = 10;
	localparam logic signed [19:0] CONV_ROUND = 20'sh00200;
	localparam logic signed [19:0] CHROMA_OFS = 20'sh20000;
	localparam logic signed [19:0] Y_R = 20'sd306;
	localparam logic signed [19:0] Y_G = 20'sd601;
	localparam logic signed [19:0] Y_B = 20'sd117;
	localparam logic signed [19:0] CB_R = -20'sd173;
	localparam logic signed [19:0] CB_G = -20'sd339;
	localparam logic signed [19:0] CB_B = 20'sd512;
	localparam logic signed [19:0] CR_R = 20'sd512;
	localparam logic signed [19:0] CR_G = -20'sd429;
	localparam logic signed [19:0] CR_B = -20'sd83;

	typedef enum logic [1:0] {
		POF_FILL = 2'b01,
		POF_DRAIN = 2'b10
	} pof_phase_t;

	typedef struct packed {
		logic sof;
		logic eol;
		logic eof;
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
		logic [13:0] raw;
	} pof_pix_in_t;

	typedef struct packed {
		logic sof;
		logic eol;
		logic eof;
		logic [2:0] nbytes;
		logic [31:0] data;
	} pof_pix_out_t;

	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
		logic [15:0] raw16;
	} pof_cell_t;
endpackage : pof_pkg

// ===== pof_sensor_model.sv
// sensor front end model: one raster frame per start pulse
`timescale 1ns/1ps
module pof_sensor_model #(
	parameter int W = 64,
	parameter int H = 5
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic grad,
	input wire pof_pkg::pof_pix_in_t tmpl,
	input wire logic in_ready,
	output logic in_valid,
	output pof_pkg::pof_pix_in_t in_pix,
	output logic busy
);
	int x;
	int y;
	function automatic pof_pkg::pof_pix_in_t mk(input int px, py);
		pof_pkg::pof_pix_in_t p;
		p = tmpl;
		if (grad)
			p.r = 8'(py * W + px);
		p.sof = px == 0 && py == 0;
		p.eol = px == W - 1;
		p.eof = px == W - 1 && py == H - 1;
		return p;
	endfunction : mk
	// idle data shows the inverse of the last pixel, never a stale copy
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_valid <= 1'b0;
			busy <= 1'b0;
			in_pix <= '0;
			x <= 0;
			y <= 0;
		end else if (start && !busy) begin
			busy <= 1'b1;
			in_valid <= 1'b1;
			in_pix <= mk(0, 0);
			x <= 0;
			y <= 0;
		end else if (in_valid && in_ready) begin
			if (in_pix.eof) begin
				in_valid <= 1'b0;
				busy <= 1'b0;
				in_pix <= ~in_pix;
			end else begin
				in_pix <= mk((x + 1) % W, x == W - 1 ? y + 1 : y);
				x <= (x + 1) % W;
				y <= x == W - 1 ? y + 1 : y;
			end
		end
	end
endmodule : pof_sensor_model

// ===== tb_pof_formatter.sv
// self-checking bench for the pixel output formatter
`timescale 1ns/1ps
module tb_pof_formatter;
	localparam int W = 64;
	localparam int H = 5;
	localparam logic [13:0] RAWS [6] = '{14'h00FF, 14'h03FF, 14'h0FFF,
		14'h3FFF, 14'h0ABC, 14'h0ABC};
	localparam logic [15:0] EXPS [6] = '{16'hFF00, 16'hFFC0, 16'hFFF0,
		16'hFFFC, 16'h00AB, 16'hABC0};
	logic clk, reset_n, cyc, we, ack, start, grad, busy, stall;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, cur;
	logic in_valid, in_ready, out_valid, out_ready;
	pof_pkg::pof_pix_in_t in_pix, tmpl;
	pof_pkg::pof_pix_out_t out_pix;
	pof_pkg::pof_pix_out_t got_q[$];
	pof_pkg::pof_pix_out_t exp_q[$];
	int n_mismatch;
	int checks_done;

	pof_formatter #(.MAX_W(W), .MAX_H(H)) dut_u (.clk(clk),
		.reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .in_valid(in_valid), .in_ready(in_ready),
		.in_pix(in_pix), .out_valid(out_valid), .out_ready(out_ready),
		.out_pix(out_pix));
	pof_sensor_model #(.W(W), .H(H)) sens_u (.clk(clk), .reset_n(reset_n),
		.start(start), .grad(grad), .tmpl(tmpl), .in_ready(in_ready),
		.in_valid(in_valid), .in_pix(in_pix), .busy(busy));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// sink: stalls every other cycle when asked
	always @(posedge clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1)
			got_q.push_back(out_pix);
		out_ready <= stall ? ~out_ready : 1'b1;
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [37:0] g, e, input string s);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h want %h", $time, s, g, e);
		end
	endtask : chk
	task automatic wb(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		chk(38'(n < 50), 38'h1, "bus answer");
		@(posedge clk);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(a, 1'b1, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, string s);
		logic [31:0] q;
		wb(a, 1'b0, 32'h0, q);
		chk(38'(q), 38'(e), s);
	endtask : rd
	function automatic logic [31:0] ctl(input logic [3:0] f,
		input logic rx, ry, input logic [1:0] d);
		return {24'h0, d, ry, rx, f};
	endfunction : ctl
	// acquisition stopped before any depth or format change
	task automatic cfg(input logic [31:0] c);
		wr(pof_pkg::REG_CTRL, cur & 32'hFFFF_FEFF);
		wr(pof_pkg::REG_CTRL, c);
		wr(pof_pkg::REG_CTRL, c | 32'h0000_0100);
		cur = c | 32'h0000_0100;
	endtask : cfg
	task automatic put(input int x, y, w, h, input logic [34:0] wd);
		pof_pkg::pof_pix_out_t p;
		p.sof = x == 0 && y == 0;
		p.eol = x == w - 1;
		p.eof = x == w - 1 && y == h - 1;
		p.nbytes = wd[34:32];
		p.data = wd[31:0];
		exp_q.push_back(p);
	endtask : put
	function automatic logic [34:0] fmt_word(input logic [3:0] f,
		input int x, input logic [7:0] r, b, yy, cb, cr);
		logic [7:0] c2;
		logic [7:0] c4;
		c2 = x % 2 ? cr : cb;
		c4 = x % 4 ? cr : cb;
		case (f)
			pof_pkg::FMT_RGB: return {3'h3, 8'h00, b, 8'h00, r};
			pof_pkg::FMT_BGR: return {3'h3, 8'h00, r, 8'h00, b};
			pof_pkg::FMT_BGRA:
				return {3'h4, pof_pkg::ALPHA_OPAQUE, r, 8'h00, b};
			pof_pkg::FMT_Y444: return {3'h3, 8'h00, cr, cb, yy};
			pof_pkg::FMT_Y444_ALT: return {3'h3, 8'h00, cr, yy, cb};
			pof_pkg::FMT_Y422: return {3'h2, 16'h0, c2, yy};
			pof_pkg::FMT_Y422_ALT: return {3'h2, 16'h0, yy, c2};
			pof_pkg::FMT_Y411:
				return x % 2 ? {3'h1, 24'h0, yy} : {3'h2, 16'h0, c4, yy};
			pof_pkg::FMT_Y411_ALT:
				return x % 2 ? {3'h1, 24'h0, yy} : {3'h2, 16'h0, yy, c4};
			default: return '0;
		endcase
	endfunction : fmt_word
	task automatic run_frame(input string s);
		int n;
		got_q.delete();
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		while ((got_q.size() < exp_q.size() || busy) && n < 4000) begin
			@(posedge clk);
			n++;
		end
		// extra pixels would land here
		repeat (4) @(posedge clk);
		chk(38'(got_q.size()), 38'(exp_q.size()), s);
		foreach (exp_q[i])
			chk(i < got_q.size() ? got_q[i] : '1, exp_q[i], s);
		exp_q.delete();
	endtask : run_frame
	task automatic print_verdict();
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////
	initial begin
		#3_000_000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		logic [3:0] f;
		logic bl;
		logic [7:0] yy, cb, cr;
		logic [31:0] q;
		int e;
		{cyc, we, start, grad, stall} = '0;
		sel = 4'hF;
		adr = 8'h00;
		wdat = 32'h0;
		cur = 32'h0;
		tmpl = '0;
		out_ready = 1'b1;
		n_mismatch = 0;
		checks_done = 0;
		reset_n = 1'b0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(pof_pkg::REG_CTRL, pof_pkg::CTRL_RESET, "ctrl reset");
		rd(pof_pkg::REG_ROI_SIZE, 32'hFFFF_FFFF, "roi size reset");
		rd(pof_pkg::REG_PATTERN, 32'h0, "pattern reset");
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, 32'h0, "unmapped");
		// only enabled byte lanes may change
		sel <= 4'h5;
		wr(pof_pkg::REG_ROI_OFFSET, 32'h1234_5678);
		sel <= 4'hF;
		rd(pof_pkg::REG_ROI_OFFSET, 32'h0034_0078, "byte lanes");
		wr(pof_pkg::REG_ROI_OFFSET, 32'h0);
		// pure red, then pure blue whose blue chroma saturates
		for (int k = 0; k < 18; k++) begin
			f = 4'(k % 9);
			bl = k >= 9;
			tmpl.r <= bl ? 8'h00 : 8'hFF;
			tmpl.b <= bl ? 8'hFF : 8'h00;
			yy = bl ? 8'h1D : 8'h4C;
			cb = bl ? 8'hFF : 8'h55;
			cr = bl ? 8'h6B : 8'hFF;
			cfg(ctl(f, 1'b0, 1'b0, pof_pkg::ADC_8));
			for (int y = 0; y < H; y++)
				for (int x = 0; x < W; x++)
					put(x, y, W, H, fmt_word(f, x, tmpl.r, tmpl.b, yy, cb, cr));
			run_frame("colour");
		end
		for (int k = 0; k < 6; k++) begin
			tmpl.raw <= RAWS[k];
			cfg(ctl(k == 4 ? pof_pkg::FMT_MOSAIC_8 : pof_pkg::FMT_MOSAIC_16,
				1'b0, 1'b0, k < 4 ? 2'(k) : pof_pkg::ADC_12));
			for (int y = 0; y < H; y++)
				for (int x = 0; x < W; x++)
					put(x, y, W, H, {k == 4 ? 3'h1 : 3'h2, 16'h0, EXPS[k]});
			run_frame("depth");
		end
		grad <= 1'b1;
		stall <= 1'b1;
		tmpl <= '0;
		wr(pof_pkg::REG_ROI_OFFSET, 32'h0001_0002);
		wr(pof_pkg::REG_ROI_SIZE, 32'h0002_0003);
		for (int m = 0; m < 4; m++) begin
			cfg(ctl(pof_pkg::FMT_RGB, m[0], m[1], pof_pkg::ADC_8));
			wb(pof_pkg::REG_STATUS, 1'b0, 32'h0, q);
			chk(38'(q[1:0]), 38'(m[1:0]), "phase");
			for (int j = 0; j < 2; j++)
				for (int i = 0; i < 3; i++) begin
					e = (m[1] ? H - 2 - j : 1 + j) * W + (m[0] ? W - 3 - i : 2 + i);
					put(i, j, 3, 2, {3'h3, 24'h0, 8'(e)});
				end
			run_frame("mirror crop");
		end
		stall <= 1'b0;
		grad <= 1'b0;
		tmpl.r <= 8'hFF;
		wr(pof_pkg::REG_ROI_OFFSET, 32'h0);
		wr(pof_pkg::REG_ROI_SIZE, 32'hFFFF_FFFF);
		// no exposure or gain loop exists here to switch off
		cfg(ctl(pof_pkg::FMT_RGB, 1'b0, 1'b0, pof_pkg::ADC_8));
		wr(pof_pkg::REG_PATTERN, 32'h2);
		wr(pof_pkg::REG_PATTERN, 32'h5);
		rd(pof_pkg::REG_PATTERN, 32'hB, "both on");
		for (int s = 0; s < 2; s++) begin
			for (int y = 0; y < H; y++)
				for (int x = 0; x < W; x++)
					put(x, y, W, H, {3'h3, 8'h00, {3{8'(y * W + x)}}});
			run_frame("ramp");
		end
		wr(pof_pkg::REG_PATTERN, 32'h1);
		rd(pof_pkg::REG_PATTERN, 32'h3, "pipe off");
		wr(pof_pkg::REG_PATTERN, 32'h0);
		rd(pof_pkg::REG_PATTERN, 32'h0, "sensor off");
		for (int y = 0; y < H; y++)
			for (int x = 0; x < W; x++)
				put(x, y, W, H, {3'h3, 32'h0000_00FF});
		run_frame("live");
		wr(pof_pkg::REG_PATTERN, 32'h7);
		cfg(ctl(pof_pkg::FMT_RGB, 1'b0, 1'b0, pof_pkg::ADC_8));
		for (int s = 0; s < 2; s++) begin
			for (int y = 0; y < H; y++)
				for (int x = 0; x < W; x++)
					put(x, y, W, H, {3'h3, 8'h00, {3{8'(x + y + s)}}});
			run_frame("sequence");
		end
		// sensor generator alone: 8 px checker squares
		wr(pof_pkg::REG_PATTERN, 32'h2);
		wr(pof_pkg::REG_PATTERN, 32'h1);
		for (int y = 0; y < H; y++)
			for (int x = 0; x < W; x++)
				put(x, y, W, H, {3'h3, 8'h00,
					{3{(x / 8 + y / 8) % 2 ? 8'hFF : 8'h00}}});
		run_frame("sensor pattern");
		rd(pof_pkg::REG_STATUS, 32'h0022_0000, "frame count");
		print_verdict();
	end
endmodule : tb_pof_formatter
